// file: hdl/urml_map.svh
`ifndef URML_MAP_SVH
`define URML_MAP_SVH

// ==========================================================================
// register offsets on the three address lines
`define URML_OFS_DATA       3'h0
`define URML_OFS_IER        3'h1
`define URML_OFS_ISR        3'h2
`define URML_OFS_LCR        3'h3
`define URML_OFS_MCR        3'h4
`define URML_OFS_LSR        3'h5
`define URML_OFS_MSR        3'h6
`define URML_OFS_SPR        3'h7

// ==========================================================================
// field positions and page codes
`define URML_LCR_PAGE_BIT   7
`define URML_LCR_BREAK_BIT  6
`define URML_ENH_PAGE       8'hbf
`define URML_MCR_LOOP_BIT   4
`define URML_EFR_ENH_BIT    4
`define URML_EFR_ACTS_BIT   7
`define URML_EFR_ARTS_BIT   6
`define URML_FCR_EN_BIT     0
`define URML_FCR_TXRST_BIT  2
`define URML_ENH_MASK       8'hf0
`define URML_FCR_ENH_MASK   8'h30
`define URML_MCR_ENH_MASK   8'he0

// ==========================================================================
// reset values
`define URML_REG_RESET      8'h00

// ==========================================================================
// interrupt source codes
`define URML_ISR_NONE       4'h1
`define URML_ISR_LINE       4'h6
`define URML_ISR_RXDATA     4'h4
`define URML_ISR_TXEMPTY    4'h2
`define URML_ISR_MODEM      4'h0

// ==========================================================================
// timing counts, in baud ticks
`define URML_TICKS_PER_BIT  4'hf
`define URML_TICKS_HALF     4'h7

`endif

// file: hdl/urml_pkg.sv
package urml_pkg;

  typedef enum logic [1:0] {
    URML_SER_IDLE,
    URML_SER_START,
    URML_SER_DATA,
    URML_SER_STOP
  } urml_ser_state_type;

  typedef logic [7:0] urml_byte_type;
  typedef logic [2:0] urml_addr_type;

endpackage : urml_pkg

// file: hdl/urml_channel.sv
// Notes on behaviour
// - modem_control bit 4 switches internal loopback
// - loopback keeps normal functions running, except automatic RTS/CTS
// - transmit serial output feeds receiver in loopback
// - loopback holds transmit, RTS and DTR pins
// - loopback ignores external modem inputs
// - no automatic RTS/CTS while in loopback
// - own registers, chip select plus three address lines
// - line_control bit 7 low: offset 0 data
// - divisor page: offsets 0,1 divisor bytes
// - offset 2 divisor_fraction needs enhanced enable
// - zero divisor: offset 0 reads revision_code
// - zero divisor: offset 1 reads identification_code
// - bit 7 low: offset 1 interrupt_enable
// - bit 7 low: offset 2 status/fifo control
// - offset 3 always line_control
// - offsets 4,5 modem_control and line_status
// - offsets 6,7 modem_status and scratch
// - 0xbf page: offset 2 enhanced_function
// - 0xbf page: offsets 4-7 resume/pause chars
// - enhanced bits writable only with enable
`timescale 1ns/1ps
`include "urml_map.svh"
`default_nettype none

// ==========================================================================
// transmit buffer
module urml_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = count_r != (AW+1)'(DEPTH);
  assign out_valid = count_r != '0;
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else if (flush)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule : urml_fifo

// ==========================================================================
// one serial channel: register map, serial shifters, loopback
module urml_channel #(
  parameter urml_pkg::urml_byte_type REVISION_CODE = 8'h01, // arbitrary
  parameter urml_pkg::urml_byte_type IDENT_CODE    = 8'h5a, // arbitrary
  parameter int                      TX_DEPTH      = 32
) (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  // host bus pins
  input  wire logic                   channel_a_select_n,
  input  wire urml_pkg::urml_addr_type addr,
  input  wire logic                   rd_n,
  input  wire logic                   wr_n,
  input  wire urml_pkg::urml_byte_type data_in,
  output urml_pkg::urml_byte_type     data_out,
  output logic                        data_oe,
  // serial and modem pins
  input  wire logic                   rx_pin,
  input  wire logic                   cts_n,
  input  wire logic                   dsr_n,
  input  wire logic                   carrier_detect_n,
  input  wire logic                   ring_indicator_n,
  output logic                        tx_pin,
  output logic                        rts_n,
  output logic                        dtr_n
);
  import urml_pkg::*;

  // ========================================================================
  // pin synchronisers
  localparam int SW = 19;
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_r <= '1;
      sync2_r <= '1;
    end
    else
    begin
      sync1_r <= {rx_pin, cts_n, dsr_n, carrier_detect_n, ring_indicator_n,
                  channel_a_select_n, rd_n, wr_n, addr, data_in};
      sync2_r <= sync1_r;
    end
  end

  logic          rx_s;
  logic          cts_n_s;
  logic          dsr_n_s;
  logic          cd_n_s;
  logic          ri_n_s;
  logic          cs_n_s;
  logic          rd_n_s;
  logic          wr_n_s;
  urml_addr_type addr_s;
  urml_byte_type din_s;
  assign {rx_s, cts_n_s, dsr_n_s, cd_n_s, ri_n_s, cs_n_s, rd_n_s, wr_n_s,
          addr_s, din_s} = sync2_r;

  // ========================================================================
  // strobe edges
  logic rd_prev_r;
  logic wr_prev_r;
  logic rd_edge;
  logic wr_edge;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_prev_r <= 1'b1;
      wr_prev_r <= 1'b1;
    end
    else
    begin
      rd_prev_r <= rd_n_s;
      wr_prev_r <= wr_n_s;
    end
  end

  // only this channel's select opens the register set
  assign rd_edge = rd_prev_r && !rd_n_s && !cs_n_s;
  assign wr_edge = wr_prev_r && !wr_n_s && !cs_n_s;

  // ========================================================================
  // register storage and page decode
  urml_byte_type lcr_r;
  urml_byte_type mcr_r;
  urml_byte_type ier_r;
  urml_byte_type fcr_r;
  urml_byte_type efr_r;
  urml_byte_type dll_r;
  urml_byte_type dlm_r;
  urml_byte_type dld_r;
  urml_byte_type spr_r;
  urml_byte_type xon1_r;
  urml_byte_type xon2_r;
  urml_byte_type xoff1_r;
  urml_byte_type xoff2_r;
  logic          enh_page;
  logic          div_page;
  logic          enh_on;
  logic          div_zero;
  logic          loop;
  urml_byte_type enh_keep;

  assign enh_page = lcr_r == `URML_ENH_PAGE;
  assign div_page = lcr_r[`URML_LCR_PAGE_BIT] && !enh_page;
  assign enh_on   = efr_r[`URML_EFR_ENH_BIT];
  assign div_zero = (dll_r == 8'h00) && (dlm_r == 8'h00);
  assign loop     = mcr_r[`URML_MCR_LOOP_BIT];
  // gated bits keep their old value while the enable is off
  assign enh_keep = enh_on ? 8'h00 : 8'hff;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lcr_r   <= `URML_REG_RESET;
      mcr_r   <= `URML_REG_RESET;
      ier_r   <= `URML_REG_RESET;
      fcr_r   <= `URML_REG_RESET;
      efr_r   <= `URML_REG_RESET;
      dll_r   <= `URML_REG_RESET;
      dlm_r   <= `URML_REG_RESET;
      dld_r   <= `URML_REG_RESET;
      spr_r   <= `URML_REG_RESET;
      xon1_r  <= `URML_REG_RESET;
      xon2_r  <= `URML_REG_RESET;
      xoff1_r <= `URML_REG_RESET;
      xoff2_r <= `URML_REG_RESET;
    end
    else if (wr_edge)
    begin
      unique case (addr_s)
        `URML_OFS_DATA:
          if (div_page)
            dll_r <= din_s;
        `URML_OFS_IER:
          if (div_page)
            dlm_r <= din_s;
          else if (!lcr_r[`URML_LCR_PAGE_BIT])
            ier_r <= (din_s & ~(`URML_ENH_MASK & enh_keep))
                   | (ier_r & `URML_ENH_MASK & enh_keep);
        `URML_OFS_ISR:
          if (enh_page)
            efr_r <= din_s;
          else if (div_page && enh_on)
            dld_r <= din_s;
          else if (!div_page)
            fcr_r <= (din_s & ~(`URML_FCR_ENH_MASK & enh_keep))
                   | (fcr_r & `URML_FCR_ENH_MASK & enh_keep);
        `URML_OFS_LCR:
          lcr_r <= din_s;
        `URML_OFS_MCR:
          if (enh_page)
            xon1_r <= din_s;
          else
            mcr_r <= (din_s & ~(`URML_MCR_ENH_MASK & enh_keep))
                   | (mcr_r & `URML_MCR_ENH_MASK & enh_keep);
        `URML_OFS_LSR:
          if (enh_page)
            xon2_r <= din_s;
        `URML_OFS_MSR:
          if (enh_page)
            xoff1_r <= din_s;
        `URML_OFS_SPR:
          if (enh_page)
            xoff2_r <= din_s;
          else
            spr_r <= din_s;
      endcase
    end
  end

  // ========================================================================
  // baud tick, sixteen per bit
  logic [15:0] divisor;
  logic [15:0] baud_cnt_r;
  logic        tick;

  assign divisor = {dlm_r, dll_r};
  assign tick    = (divisor != 16'h0000) && (baud_cnt_r == 16'h0000);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      baud_cnt_r <= 16'h0000;
    else if (divisor == 16'h0000)
      baud_cnt_r <= 16'h0000;
    else if (baud_cnt_r == 16'h0000)
      baud_cnt_r <= divisor - 16'h0001;
    else
      baud_cnt_r <= baud_cnt_r - 16'h0001;
  end

  // ========================================================================
  // transmit path
  logic               thr_push;
  logic               txf_ready;
  logic               txf_valid;
  urml_byte_type      txf_data;
  logic               tx_take;
  logic               cts_block;
  urml_ser_state_type tx_state_r;
  urml_byte_type      tx_shift_r;
  logic [2:0]         tx_bit_r;
  logic [3:0]         tx_tick_r;
  logic               tx_ser_r;
  logic [2:0]         last_bit;

  assign thr_push = wr_edge && (addr_s == `URML_OFS_DATA)
                  && !lcr_r[`URML_LCR_PAGE_BIT];
  assign last_bit = 3'h4 + {1'b0, lcr_r[1:0]};
  // auto cts holds off the next character, but never in loopback
  assign cts_block = efr_r[`URML_EFR_ACTS_BIT] && cts_n_s && !loop;
  assign tx_take  = (tx_state_r == URML_SER_IDLE) && txf_valid && !cts_block;

  // a write into a full buffer is dropped; line_status bit 5 only shows the buffer empty
  urml_fifo #(
    .WIDTH (8),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .flush     (wr_edge && (addr_s == `URML_OFS_ISR) && !enh_page
                && !div_page && din_s[`URML_FCR_TXRST_BIT]),
    .in_valid  (thr_push),
    .in_ready  (txf_ready),
    .in_data   (din_s),
    .out_valid (txf_valid),
    .out_ready (tx_take),
    .out_data  (txf_data)
  );

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_state_r <= URML_SER_IDLE;
      tx_shift_r <= 8'h00;
      tx_bit_r   <= 3'h0;
      tx_tick_r  <= 4'h0;
      tx_ser_r   <= 1'b1;
    end
    else if (tx_take)
    begin
      tx_state_r <= URML_SER_START;
      tx_shift_r <= txf_data;
      tx_bit_r   <= 3'h0;
      tx_tick_r  <= 4'h0;
      tx_ser_r   <= 1'b0;
    end
    else if (tick && (tx_state_r != URML_SER_IDLE))
    begin
      tx_tick_r <= tx_tick_r + 4'h1;
      if (tx_tick_r == `URML_TICKS_PER_BIT)
      begin
        unique case (tx_state_r)
          URML_SER_START:
          begin
            tx_state_r <= URML_SER_DATA;
            tx_ser_r   <= tx_shift_r[0];
          end
          URML_SER_DATA:
            if (tx_bit_r == last_bit)
            begin
              tx_state_r <= URML_SER_STOP;
              tx_ser_r   <= 1'b1;
            end
            else
            begin
              tx_bit_r   <= tx_bit_r + 3'h1;
              tx_shift_r <= {1'b0, tx_shift_r[7:1]};
              tx_ser_r   <= tx_shift_r[1];
            end
          URML_SER_STOP:
            tx_state_r <= URML_SER_IDLE;
          URML_SER_IDLE:
            tx_state_r <= URML_SER_IDLE;
        endcase
      end
    end
  end

  // ========================================================================
  // receive path
  logic               rx_src;
  urml_ser_state_type rx_state_r;
  urml_byte_type      rx_shift_r;
  logic [2:0]         rx_bit_r;
  logic [3:0]         rx_tick_r;
  urml_byte_type      rhr_r;
  logic               rx_ready_r;
  logic               overrun_r;
  logic               frame_err_r;
  logic               break_r;
  logic               rx_done;
  logic               rhr_pop;
  logic               lsr_rd;

  // loopback feeds the receiver from the transmit shifter, not the pin
  assign rx_src  = loop ? tx_ser_r : rx_s;
  assign rx_done = tick && (rx_state_r == URML_SER_STOP)
                 && (rx_tick_r == `URML_TICKS_PER_BIT);
  assign rhr_pop = rd_edge && (addr_s == `URML_OFS_DATA)
                 && !lcr_r[`URML_LCR_PAGE_BIT];
  assign lsr_rd  = rd_edge && (addr_s == `URML_OFS_LSR) && !enh_page;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_state_r <= URML_SER_IDLE;
      rx_shift_r <= 8'h00;
      rx_bit_r   <= 3'h0;
      rx_tick_r  <= 4'h0;
    end
    else if (tick)
    begin
      rx_tick_r <= rx_tick_r + 4'h1;
      unique case (rx_state_r)
        URML_SER_IDLE:
          if (!rx_src)
          begin
            rx_state_r <= URML_SER_START;
            rx_tick_r  <= 4'h0;
          end
        URML_SER_START:
          if (rx_tick_r == `URML_TICKS_HALF)
          begin
            rx_tick_r  <= 4'h0;
            rx_bit_r   <= 3'h0;
            rx_shift_r <= 8'h00;
            rx_state_r <= rx_src ? URML_SER_IDLE : URML_SER_DATA;
          end
        URML_SER_DATA:
          if (rx_tick_r == `URML_TICKS_PER_BIT)
          begin
            rx_shift_r <= rx_shift_r | (urml_byte_type'(rx_src) << rx_bit_r);
            rx_bit_r   <= rx_bit_r + 3'h1;
            if (rx_bit_r == last_bit)
              rx_state_r <= URML_SER_STOP;
          end
        URML_SER_STOP:
          if (rx_tick_r == `URML_TICKS_PER_BIT)
            rx_state_r <= URML_SER_IDLE;
      endcase
    end
  end

  // a new character or error wins over a clearing read in the same cycle
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rhr_r       <= 8'h00;
      rx_ready_r  <= 1'b0;
      overrun_r   <= 1'b0;
      frame_err_r <= 1'b0;
      break_r     <= 1'b0;
    end
    else if (rx_done)
    begin
      rhr_r       <= rx_shift_r;
      rx_ready_r  <= 1'b1;
      overrun_r   <= rx_ready_r && !rhr_pop ? 1'b1 : overrun_r && !lsr_rd;
      frame_err_r <= !rx_src;
      break_r     <= !rx_src && (rx_shift_r == 8'h00);
    end
    else
    begin
      if (rhr_pop)
        rx_ready_r <= 1'b0;
      if (lsr_rd)
      begin
        overrun_r   <= 1'b0;
        frame_err_r <= 1'b0;
        break_r     <= 1'b0;
      end
    end
  end

  // ========================================================================
  // modem inputs, seen active high
  logic [3:0] modem_in;
  logic [3:0] modem_prev_r;
  logic [3:0] delta_r;
  logic       msr_rd;

  // loopback swaps the pins for the modem_control outputs
  assign modem_in = loop ? mcr_r[3:0]
                         : {~cd_n_s, ~ri_n_s, ~dsr_n_s, ~cts_n_s};
  assign msr_rd   = rd_edge && (addr_s == `URML_OFS_MSR) && !enh_page;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      modem_prev_r <= 4'h0;
      delta_r      <= 4'h0;
    end
    else
    begin
      modem_prev_r <= modem_in;
      delta_r      <= (msr_rd ? 4'h0 : delta_r)
                    | ((modem_in ^ modem_prev_r)
                       & {2'b11, 1'b1, 1'b1}
                       & ~{1'b0, modem_in[2], 2'b00});
    end
  end

  // ========================================================================
  // read mux
  logic          tx_idle;
  logic [3:0]    isr_code;
  urml_byte_type lsr_val;
  urml_byte_type msr_val;
  urml_byte_type rd_val;

  assign tx_idle = !txf_valid && (tx_state_r == URML_SER_IDLE);
  assign lsr_val = {overrun_r | frame_err_r | break_r, tx_idle, !txf_valid,
                    break_r, frame_err_r, 1'b0, overrun_r, rx_ready_r};
  assign msr_val = {modem_in[3], modem_in[2], modem_in[1], modem_in[0],
                    delta_r[3], delta_r[2], delta_r[1], delta_r[0]};

  always_comb
  begin
    if (ier_r[2] && (overrun_r || frame_err_r || break_r))
      isr_code = `URML_ISR_LINE;
    else if (ier_r[0] && rx_ready_r)
      isr_code = `URML_ISR_RXDATA;
    else if (ier_r[1] && !txf_valid)
      isr_code = `URML_ISR_TXEMPTY;
    else if (ier_r[3] && (delta_r != 4'h0))
      isr_code = `URML_ISR_MODEM;
    else
      isr_code = `URML_ISR_NONE;
  end

  always_comb
  begin
    rd_val = 8'h00;
    unique case (addr_s)
      `URML_OFS_DATA:
        if (!lcr_r[`URML_LCR_PAGE_BIT])
          rd_val = rhr_r;
        else if (div_page)
          rd_val = div_zero ? REVISION_CODE : dll_r;
      `URML_OFS_IER:
        if (!lcr_r[`URML_LCR_PAGE_BIT])
          rd_val = ier_r & ~(`URML_ENH_MASK & enh_keep);
        else if (div_page)
          rd_val = div_zero ? IDENT_CODE : dlm_r;
      `URML_OFS_ISR:
        if (enh_page)
          rd_val = efr_r;
        else if (div_page && enh_on)
          rd_val = dld_r;
        else
          rd_val = {{2{fcr_r[`URML_FCR_EN_BIT]}}, 2'b00, isr_code};
      `URML_OFS_LCR:
        rd_val = lcr_r;
      `URML_OFS_MCR:
        rd_val = enh_page ? xon1_r
               : mcr_r & ~(`URML_MCR_ENH_MASK & enh_keep);
      `URML_OFS_LSR:
        rd_val = enh_page ? xon2_r : lsr_val;
      `URML_OFS_MSR:
        rd_val = enh_page ? xoff1_r : msr_val;
      `URML_OFS_SPR:
        rd_val = enh_page ? xoff2_r : spr_r;
    endcase
  end

  // ========================================================================
  // output pins, all registered
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end
    else
    begin
      data_oe <= !rd_n_s && !cs_n_s;
      if (rd_edge)
        data_out <= rd_val;
    end
  end

  // loopback parks the pins idle; the shifters keep running inside
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_pin <= 1'b1;
      rts_n  <= 1'b1;
      dtr_n  <= 1'b1;
    end
    else
    begin
      tx_pin <= loop ? 1'b1
              : tx_ser_r && !lcr_r[`URML_LCR_BREAK_BIT];
      rts_n  <= loop ? 1'b1
              : efr_r[`URML_EFR_ARTS_BIT] ? rx_ready_r
              : !mcr_r[1];
      dtr_n  <= loop ? 1'b1 : !mcr_r[0];
    end
  end

endmodule : urml_channel
`default_nettype wire

// file: verif/urml_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// port checks for one channel
module urml_checker
  import urml_pkg::*;
(
  // clock and reset
  input wire logic          core_clk,
  input wire logic          nrst,
  // host bus
  input wire logic          channel_a_select_n,
  input wire urml_addr_type addr,
  input wire logic          rd_n,
  input wire logic          wr_n,
  input wire urml_byte_type data_in,
  input wire urml_byte_type data_out,
  input wire logic          data_oe,
  // serial and modem pins
  input wire logic          tx_pin,
  input wire logic          rts_n,
  input wire logic          dtr_n
);
  // shadow taken on the raw pins, so it leads the design by the sync delay
  urml_byte_type lcr_r;
  logic          loop_r;
  logic          brk_w;
  assign brk_w = lcr_r[6] && !loop_r;
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      lcr_r <= 8'h00;
    else if ($fell(wr_n) && !channel_a_select_n && addr == 3'h3)
      lcr_r <= data_in;
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      loop_r <= 1'b0;
    else if ($fell(wr_n) && !channel_a_select_n && addr == 3'h4
             && lcr_r != 8'hbf)
      loop_r <= data_in[4];
  sequence rd_held;
    (!rd_n && !channel_a_select_n) [*4];
  endsequence
  sequence bus_idle;
    (rd_n || channel_a_select_n) [*4];
  endsequence
  a_reset_pins_idle: assert property (@(posedge core_clk)
    !nrst |-> !data_oe && tx_pin && rts_n && dtr_n)
    else $error("pins not idle in reset");
  a_oe_needs_read: assert property (@(posedge core_clk)
    disable iff (!nrst) $rose(data_oe) |-> !$past(rd_n, 2)
    && !$past(channel_a_select_n, 2)) else $error("drive without read");
  a_oe_on_read: assert property (@(posedge core_clk)
    disable iff (!nrst) rd_held |-> data_oe)
    else $error("read not driven");
  a_oe_release: assert property (@(posedge core_clk)
    disable iff (!nrst) $rose(rd_n) |-> ##[1:3] !data_oe)
    else $error("bus not released");
  a_no_idle_drive: assert property (@(posedge core_clk)
    disable iff (!nrst) bus_idle |-> !data_oe)
    else $error("bus driven while idle");
  a_data_on_read: assert property (@(posedge core_clk)
    disable iff (!nrst) $changed(data_out) |-> $rose(data_oe))
    else $error("read data moved outside a read");
  a_loop_pins_held: assert property (@(posedge core_clk)
    disable iff (!nrst) loop_r && $past(loop_r, 5) |->
    tx_pin && rts_n && dtr_n) else $error("pins moved in loopback");
  a_break_drives_low: assert property (@(posedge core_clk)
    disable iff (!nrst) brk_w && $past(brk_w, 5) |-> !tx_pin)
    else $error("break not on line");
endmodule : urml_checker
`default_nettype wire

// file: verif/urml_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// far end of the serial line: echo or idle mark, modem levels
module urml_line_model (
  // from the channel
  input wire logic       tx_pin,
  // scenario controls
  input wire logic       echo,
  input wire logic [3:0] modem_lvl,
  // to the channel
  output logic           rx_pin,
  output logic           cts_n,
  output logic           dsr_n,
  output logic           carrier_detect_n,
  output logic           ring_indicator_n
);
  // mark level unless echoing, so no false break after loopback
  assign rx_pin = echo ? tx_pin : 1'b1;
  assign {carrier_detect_n, ring_indicator_n, dsr_n, cts_n} = modem_lvl;
endmodule : urml_line_model
`default_nettype wire

// file: verif/urml_channel_test.sv
`timescale 1ns/1ps
`default_nettype none
module urml_channel_test;
  import urml_pkg::*;
  localparam urml_byte_type REV = 8'h3c; // arbitrary
  localparam urml_byte_type IDV = 8'h96; // arbitrary
  logic          core_clk = 1'b0;
  logic          nrst = 1'b1;
  logic          cs_n = 1'b1;
  urml_addr_type addr = 3'h0;
  logic          rd_n = 1'b1;
  logic          wr_n = 1'b1;
  urml_byte_type data_in = 8'h00;
  urml_byte_type data_out;
  urml_byte_type v;
  logic          data_oe, rx_pin, cts_n, dsr_n, cd_n, ri_n;
  logic          tx_pin, rts_n, dtr_n;
  logic          echo = 1'b0;
  logic [3:0]    modem_lvl = 4'hf;
  int            failures = 0;
  int            num_checks = 0;
  always #2 core_clk = ~core_clk;
  urml_channel #(.REVISION_CODE(REV), .IDENT_CODE(IDV), .TX_DEPTH(32))
    i_urml_channel (.core_clk(core_clk), .nrst(nrst),
    .channel_a_select_n(cs_n), .addr(addr), .rd_n(rd_n), .wr_n(wr_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .rx_pin(rx_pin), .cts_n(cts_n), .dsr_n(dsr_n), .carrier_detect_n(cd_n),
    .ring_indicator_n(ri_n), .tx_pin(tx_pin), .rts_n(rts_n), .dtr_n(dtr_n));
  urml_line_model i_urml_line_model (.tx_pin(tx_pin), .echo(echo),
    .modem_lvl(modem_lvl), .rx_pin(rx_pin), .cts_n(cts_n), .dsr_n(dsr_n),
    .carrier_detect_n(cd_n), .ring_indicator_n(ri_n));
  // ========================================================================
  // host bus tasks; write strobe stays low 4 cycles, read strobe 5, to cover the 2-flop sync
  task automatic chk(input string n, input urml_byte_type e,
                     input urml_byte_type g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input urml_addr_type a, input urml_byte_type d);
    @(posedge core_clk);
    cs_n <= 1'b0;
    addr <= a;
    data_in <= d;
    repeat (3) @(posedge core_clk);
    wr_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    wr_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    cs_n <= 1'b1;
  endtask : wr
  task automatic rd(input urml_addr_type a, output urml_byte_type d);
    @(posedge core_clk);
    cs_n <= 1'b0;
    addr <= a;
    repeat (3) @(posedge core_clk);
    rd_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1 d = data_out;
    @(posedge core_clk);
    rd_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    cs_n <= 1'b1;
  endtask : rd
  task automatic rc(input urml_addr_type a, input urml_byte_type e,
                    input urml_byte_type m = 8'hff);
    rd(a, v);
    chk($sformatf("offset %0d", a), e & m, v & m);
  endtask : rc
  task automatic wait_rx(input urml_byte_type e);
    for (int n = 0; n < 40; n++)
    begin
      rd(3'h5, v);
      if (v[0] === 1'b1)
        break;
    end
    chk("data ready", 8'h01, v & 8'h01);
    rc(3'h0, e);
  endtask : wait_rx
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // ========================================================================
  // tests
  initial
  begin
    nrst <= 1'b0;
    fork
      begin
        #80000;
        failures++;
        print_verdict();
      end
    join_none
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    rc(3'h3, 8'h00);
    rc(3'h4, 8'h00);
    rc(3'h1, 8'h00);
    wr(3'h7, 8'ha5);
    rc(3'h7, 8'ha5);
    $display("test done: reset and scratch");
    wr(3'h3, 8'h83);
    rc(3'h0, REV);
    rc(3'h1, IDV);
    wr(3'h0, 8'h01);
    rc(3'h0, 8'h01);
    rc(3'h1, 8'h00);
    wr(3'h3, 8'hbf);
    rc(3'h3, 8'hbf);
    wr(3'h2, 8'h10);
    rc(3'h2, 8'h10);
    for (int i = 4; i < 8; i++)
      wr(3'(i), {5'h0c, 3'(i)});
    for (int i = 4; i < 8; i++)
      rc(3'(i), {5'h0c, 3'(i)});
    wr(3'h3, 8'h83);
    wr(3'h2, 8'h0b);
    rc(3'h2, 8'h0b);
    wr(3'h3, 8'h03);
    wr(3'h1, 8'hf1);
    rc(3'h1, 8'hf1);
    wr(3'h3, 8'hbf);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h03);
    rc(3'h1, 8'h01);
    wr(3'h1, 8'he2);
    rc(3'h1, 8'h02);
    rc(3'h2, 8'h02, 8'h0f);
    $display("test done: register pages");
    wr(3'h3, 8'h43);
    wr(3'h3, 8'h03);
    wr(3'h4, 8'h1a);
    rc(3'h4, 8'h1a);
    modem_lvl <= 4'h0;
    rc(3'h6, 8'ha0, 8'hf0);
    wr(3'h0, 8'h3c);
    wait_rx(8'h3c);
    $display("test done: loopback");
    wr(3'h4, 8'h00);
    modem_lvl <= 4'hf;
    echo <= 1'b1;
    wr(3'h0, 8'h5a);
    wait_rx(8'h5a);
    $display("test done: line echo");
    // slow divisor so the buffer cannot drain while it is filled
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h40);
    wr(3'h3, 8'h03);
    for (int i = 0; i < 34; i++)
      wr(3'h0, 8'(i));
    rc(3'h5, 8'h00, 8'h20);
    wr(3'h2, 8'h04);
    rc(3'h5, 8'h20, 8'h20);
    $display("test done: buffer fill and flush");
    print_verdict();
  end
endmodule : urml_channel_test
bind urml_channel urml_checker i_urml_checker (.core_clk(core_clk),
  .nrst(nrst), .channel_a_select_n(channel_a_select_n), .addr(addr),
  .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in), .data_out(data_out),
  .data_oe(data_oe), .tx_pin(tx_pin), .rts_n(rts_n), .dtr_n(dtr_n));
`default_nettype wire
